// ### core/edqo_pkg.sv
// constants, register map and reset values for the divided quadrature output
// Operation
// - divide encoder counts into a quadrature pair
// - outputs up to 2Mpps, driven differentially
// - setting 0: A leads B when turning CW
// - setting 1: B leads A, order inverted
// - index polarity: 0 active high, 1 low
// - pulses per revolution sets ratio, default 2500
// - setting selects source of division path
package edqo_pkg;

    // register offsets on the plain register port
    localparam logic [3:0]  EDQO_CTRL_OFS     = 4'h0;
    localparam logic [3:0]  EDQO_PPR_OFS      = 4'h4;
    localparam logic [3:0]  EDQO_STATUS_OFS   = 4'h8;
    localparam logic [3:0]  EDQO_COUNT_OFS    = 4'hC;

    // control field positions
    localparam int          EDQO_CTRL_DIR_BIT = 0;
    localparam int          EDQO_CTRL_POL_BIT = 1;
    localparam int          EDQO_CTRL_SRC_BIT = 2;

    // status field positions
    localparam int          EDQO_ST_A_BIT     = 0;
    localparam int          EDQO_ST_B_BIT     = 1;
    localparam int          EDQO_ST_Z_BIT     = 2;
    localparam int          EDQO_ST_OVR_BIT   = 3;
    localparam int          EDQO_ST_ERR_BIT   = 4;

    // values after reset and ppr limits
    localparam logic [2:0]  EDQO_CTRL_RST     = 3'h0;
    localparam logic [13:0] EDQO_PPR_RST      = 14'h09C4;
    localparam logic [13:0] EDQO_PPR_MIN      = 14'h000A;
    localparam logic [13:0] EDQO_PPR_MAX      = 14'h2710;

    // encoder counts (four per line) per motor revolution, plain default
    localparam logic [16:0] EDQO_ENC_CNT_REV  = 17'h09C40;

    // timing
    localparam int          EDQO_CLK_HZ       = 20_000_000;
    localparam int          EDQO_MAX_PPS      = 2_000_000;
    localparam int          EDQO_EDGE_MIN_NS  = 1_000_000_000 / (4 * EDQO_MAX_PPS);
    localparam int          EDQO_Z_MIN_NS     = 1_000_000_000 / (2 * EDQO_MAX_PPS);
    localparam int          EDQO_EDGE_CYC     =
        (EDQO_EDGE_MIN_NS * (EDQO_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int          EDQO_Z_CYC        =
        (EDQO_Z_MIN_NS * (EDQO_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [3:0]  EDQO_EDGE_CYC_V   = 4'(EDQO_EDGE_CYC);
    localparam logic [3:0]  EDQO_Z_CYC_V      = 4'(EDQO_Z_CYC);

    // pending output steps, signed, saturating
    localparam logic signed [3:0] EDQO_PEND_MAX = 4'sh7;
    localparam logic signed [3:0] EDQO_PEND_MIN = -4'sh7;

    // output source choice
    typedef enum logic [0:0] {
        EDQO_SRC_MOTOR = 1'b0,
        EDQO_SRC_AUX   = 1'b1
    } edqo_src_t;

endpackage

// ### core/edqo_top.sv
// encoder divided quadrature output with register port
`timescale 1ns/1ps
module edqo_top
    import edqo_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        enc_a_in,
    input  wire logic        enc_b_in,
    input  wire logic        enc_z_in,
    input  wire logic        aux_a_in,
    input  wire logic        aux_b_in,
    input  wire logic        aux_z_in,
    output logic             divided_phase_a_out_p,
    output logic             divided_phase_a_out_n,
    output logic             divided_phase_b_out_p,
    output logic             divided_phase_b_out_n,
    output logic             divided_index_out_p,
    output logic             divided_index_out_n
);

    // pin vector: {aux z,b,a, motor z,b,a}
    logic [5:0]        pins;
    logic [5:0]        sync1_ff;        // first stage, read only by second
    logic [5:0]        sync2_ff;
    logic [5:0]        sync3_ff;
    logic [5:0]        filt_ff;         // accepted level

    // settings
    logic [2:0]        ctrl_ff;
    logic [13:0]       output_pulses_per_rev_ff;
    logic              divided_output_direction_sel;
    logic              index_pulse_polarity_sel;
    edqo_src_t         src_sel;

    // decode
    logic              sel_a;
    logic              sel_b;
    logic              sel_z;
    logic [1:0]        qpos;            // position inside one quadrature cycle
    logic [1:0]        qpos_ff;
    logic              z_prev_ff;
    edqo_src_t         src_prev_ff;
    logic [1:0]        qdiff;
    logic              cnt_fwd;
    logic              cnt_rev;
    logic              cnt_err;

    // divider
    logic [16:0]       acc_ff;
    logic [16:0]       ppr_x4;
    logic [16:0]       acc_sum;
    logic              step_fwd;
    logic              step_rev;

    // output stepping
    logic signed [3:0] pend_ff;
    logic [3:0]        gap_ff;
    logic [1:0]        outq_ff;
    logic              out_go;
    logic              out_fwd;
    logic [3:0]        z_cnt_ff;
    logic              ovr_ff;
    logic              err_ff;
    logic [15:0]       out_cnt_ff;

    // output levels before the pin flops
    logic              nxt_a;
    logic              nxt_b;
    logic              nxt_z;
    logic              phase_a;
    logic              phase_b;

    assign pins = {aux_z_in, aux_b_in, aux_a_in, enc_z_in, enc_b_in, enc_a_in};

    assign divided_output_direction_sel = ctrl_ff[EDQO_CTRL_DIR_BIT];
    assign index_pulse_polarity_sel     = ctrl_ff[EDQO_CTRL_POL_BIT];
    assign src_sel = edqo_src_t'(ctrl_ff[EDQO_CTRL_SRC_BIT]);

    // three flop pin synchroniser, a level counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_sync
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_ff[gi] <= 1'b0;
                    sync2_ff[gi] <= 1'b0;
                    sync3_ff[gi] <= 1'b0;
                    filt_ff[gi]  <= 1'b0;
                end else begin
                    sync1_ff[gi] <= pins[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                    sync3_ff[gi] <= sync2_ff[gi];
                    // single-cycle glitches never reach the decoder
                    if (sync2_ff[gi] == sync3_ff[gi]) begin
                        filt_ff[gi] <= sync3_ff[gi];
                    end
                end
            end
        end
    endgenerate

    // source mux for the division path
    always_comb begin
        if (src_sel == EDQO_SRC_AUX) begin
            sel_a = filt_ff[3];
            sel_b = filt_ff[4];
            sel_z = filt_ff[5];
        end else begin
            sel_a = filt_ff[0];
            sel_b = filt_ff[1];
            sel_z = filt_ff[2];
        end
    end

    // quadrature decode: A leading B walks qpos downward
    assign qpos    = {sel_a, sel_a ^ sel_b};
    assign qdiff   = qpos - qpos_ff;
    // a source switch re-seeds the history instead of counting a jump
    assign cnt_fwd = (qdiff == 2'h3) && (src_prev_ff == src_sel);
    assign cnt_rev = (qdiff == 2'h1) && (src_prev_ff == src_sel);
    assign cnt_err = (qdiff == 2'h2) && (src_prev_ff == src_sel);

    // decoder history
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            qpos_ff     <= 2'h0;
            z_prev_ff   <= 1'b0;
            src_prev_ff <= EDQO_SRC_MOTOR;
        end else begin
            qpos_ff     <= qpos;
            z_prev_ff   <= sel_z;
            src_prev_ff <= src_sel;
        end
    end

    // rate accumulator: 4*ppr output edges per revolution of encoder counts
    assign ppr_x4  = {1'b0, output_pulses_per_rev_ff, 2'b00};
    assign acc_sum = acc_ff + ppr_x4;
    assign step_fwd = cnt_fwd && (acc_sum >= EDQO_ENC_CNT_REV);
    assign step_rev = cnt_rev && (acc_ff < ppr_x4);

    // divider state; reverse mirrors forward so back-and-forth motion nets to zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff <= 17'h00000;
        end else if (cnt_fwd) begin
            if (step_fwd) begin
                acc_ff <= acc_sum - EDQO_ENC_CNT_REV;
            end else begin
                acc_ff <= acc_sum;
            end
        end else if (cnt_rev) begin
            if (step_rev) begin
                acc_ff <= acc_ff + EDQO_ENC_CNT_REV - ppr_x4;
            end else begin
                acc_ff <= acc_ff - ppr_x4;
            end
        end
    end

    // an output edge may leave once the minimum edge spacing has passed
    assign out_go  = (gap_ff == 4'h0) && (pend_ff != 4'sh0);
    assign out_fwd = (pend_ff > 4'sh0);

    // pending steps between divider and pins; holds bursts above the rate limit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_ff <= 4'sh0;
        end else begin
            case ({step_fwd, step_rev, out_go})
                3'b100: pend_ff <= (pend_ff == EDQO_PEND_MAX) ? pend_ff : pend_ff + 4'sh1;
                3'b010: pend_ff <= (pend_ff == EDQO_PEND_MIN) ? pend_ff : pend_ff - 4'sh1;
                3'b001: pend_ff <= out_fwd ? pend_ff - 4'sh1 : pend_ff + 4'sh1;
                3'b101: pend_ff <= out_fwd ? pend_ff : pend_ff + 4'sh2;
                3'b011: pend_ff <= out_fwd ? pend_ff - 4'sh2 : pend_ff;
                default: pend_ff <= pend_ff;
            endcase
        end
    end

    // edge spacing counter keeps each phase under the maximum pulse rate
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_ff <= 4'h0;
        end else if (out_go) begin
            gap_ff <= EDQO_EDGE_CYC_V - 4'h1;
        end else if (gap_ff != 4'h0) begin
            gap_ff <= gap_ff - 4'h1;
        end
    end

    // output quadrature position and output pulse counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            outq_ff    <= 2'h0;
            out_cnt_ff <= 16'h0000;
        end else if (out_go) begin
            outq_ff <= out_fwd ? outq_ff + 2'h1 : outq_ff - 2'h1;
            // one full pulse every four edges
            if (out_fwd && (outq_ff == 2'h3)) begin
                out_cnt_ff <= out_cnt_ff + 16'h0001;
            end else if (!out_fwd && (outq_ff == 2'h0)) begin
                out_cnt_ff <= out_cnt_ff - 16'h0001;
            end
        end
    end

    // index pulse stretcher, started only by a rising index edge of the selected source
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            z_cnt_ff <= 4'h0;
        end else if (sel_z && !z_prev_ff && (src_prev_ff == src_sel)) begin
            z_cnt_ff <= EDQO_Z_CYC_V;
        end else if (z_cnt_ff != 4'h0) begin
            z_cnt_ff <= z_cnt_ff - 4'h1;
        end
    end

    // forward sequence with A leading: 00,10,11,01
    assign phase_a = outq_ff[0] ^ outq_ff[1];
    assign phase_b = outq_ff[1];

    // phase order and index polarity
    always_comb begin
        if (divided_output_direction_sel) begin
            nxt_a = phase_b;
            nxt_b = phase_a;
        end else begin
            nxt_a = phase_a;
            nxt_b = phase_b;
        end
        nxt_z = (z_cnt_ff != 4'h0) ^ index_pulse_polarity_sel;
    end

    // differential pin flops, both legs registered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            divided_phase_a_out_p <= 1'b0;
            divided_phase_a_out_n <= 1'b1;
            divided_phase_b_out_p <= 1'b0;
            divided_phase_b_out_n <= 1'b1;
            divided_index_out_p   <= 1'b0;
            divided_index_out_n   <= 1'b1;
        end else begin
            divided_phase_a_out_p <= nxt_a;
            divided_phase_a_out_n <= ~nxt_a;
            divided_phase_b_out_p <= nxt_b;
            divided_phase_b_out_n <= ~nxt_b;
            divided_index_out_p   <= nxt_z;
            divided_index_out_n   <= ~nxt_z;
        end
    end

    // settings registers; ppr is clamped to its legal span on write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff                  <= EDQO_CTRL_RST;
            output_pulses_per_rev_ff <= EDQO_PPR_RST;
        end else if (reg_wr) begin
            if (reg_addr == EDQO_CTRL_OFS) begin
                ctrl_ff <= reg_wdata[2:0];
            end else if (reg_addr == EDQO_PPR_OFS) begin
                if (reg_wdata[31:0] < {18'h0, EDQO_PPR_MIN}) begin
                    output_pulses_per_rev_ff <= EDQO_PPR_MIN;
                end else if (reg_wdata[31:0] > {18'h0, EDQO_PPR_MAX}) begin
                    output_pulses_per_rev_ff <= EDQO_PPR_MAX;
                end else begin
                    output_pulses_per_rev_ff <= reg_wdata[13:0];
                end
            end
        end
    end

    // sticky flags: a new event in the clearing cycle wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovr_ff <= 1'b0;
            err_ff <= 1'b0;
        end else begin
            // a step is lost only when nothing drains in the same cycle
            if (!out_go && ((step_fwd && pend_ff == EDQO_PEND_MAX) ||
                            (step_rev && pend_ff == EDQO_PEND_MIN))) begin
                ovr_ff <= 1'b1;
            end else if (reg_wr && reg_addr == EDQO_STATUS_OFS &&
                         reg_wdata[EDQO_ST_OVR_BIT]) begin
                ovr_ff <= 1'b0;
            end
            if (cnt_err) begin
                err_ff <= 1'b1;
            end else if (reg_wr && reg_addr == EDQO_STATUS_OFS &&
                         reg_wdata[EDQO_ST_ERR_BIT]) begin
                err_ff <= 1'b0;
            end
        end
    end

    // read data stand in the cycle after the strobe only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            if (reg_addr == EDQO_CTRL_OFS) begin
                reg_rdata <= {29'h0, ctrl_ff};
            end else if (reg_addr == EDQO_PPR_OFS) begin
                reg_rdata <= {18'h0, output_pulses_per_rev_ff};
            end else if (reg_addr == EDQO_STATUS_OFS) begin
                reg_rdata <= {27'h0, err_ff, ovr_ff, (z_cnt_ff != 4'h0), nxt_b, nxt_a};
            end else if (reg_addr == EDQO_COUNT_OFS) begin
                reg_rdata <= {16'h0, out_cnt_ff};
            end else begin
                reg_rdata <= 32'h00000000; // unmapped reads as zero
            end
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule

// ### verification/edqo_asserts.sv
// checker for register port and divided output pin timing
`timescale 1ns/1ps
module edqo_asserts
    import edqo_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [3:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        divided_phase_a_out_p,
    input wire logic        divided_phase_a_out_n,
    input wire logic        divided_phase_b_out_p,
    input wire logic        divided_phase_b_out_n,
    input wire logic        divided_index_out_p,
    input wire logic        divided_index_out_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // a and b rest two cycles after any edge, keeps quarter period legal
    sequence s_ab_rest;
        $stable({divided_phase_a_out_p, divided_phase_b_out_p})[*2];
    endsequence
    // index level held over the rest of its five-cycle pulse
    sequence s_z_rest;
        $stable(divided_index_out_p)[*4];
    endsequence
    // read strobe taken at the previous edge
    sequence s_rd_done;
        $past(reg_rd);
    endsequence
    property p_a_diff;
        divided_phase_a_out_n == !divided_phase_a_out_p;
    endproperty
    property p_b_diff;
        divided_phase_b_out_n == !divided_phase_b_out_p;
    endproperty
    property p_z_diff;
        divided_index_out_n == !divided_index_out_p;
    endproperty
    property p_edge_gap;
        $changed({divided_phase_a_out_p, divided_phase_b_out_p}) |=> s_ab_rest;
    endproperty
    property p_one_phase;
        !($changed(divided_phase_a_out_p) && $changed(divided_phase_b_out_p));
    endproperty
    property p_z_width;
        $changed(divided_index_out_p) |=> s_z_rest;
    endproperty
    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 32'h0;
    endproperty
    property p_ppr_range;
        s_rd_done ##0 ($past(reg_addr) == EDQO_PPR_OFS)
            |-> reg_rdata inside {[32'h0000000A:32'h00002710]};
    endproperty
    property p_ctrl_width;
        s_rd_done ##0 ($past(reg_addr) == EDQO_CTRL_OFS) |-> reg_rdata[31:3] == 29'h0;
    endproperty
    a_a_diff: assert property (p_a_diff) else $error("phase a pair not complementary");
    a_b_diff: assert property (p_b_diff) else $error("phase b pair not complementary");
    a_z_diff: assert property (p_z_diff) else $error("index pair not complementary");
    a_edge_gap: assert property (p_edge_gap) else $error("output edges too close");
    a_one_phase: assert property (p_one_phase) else $error("a and b moved together");
    a_z_width: assert property (p_z_width) else $error("index pulse too short");
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
    a_ppr_range: assert property (p_ppr_range) else $error("pulse count out of range");
    a_ctrl_width: assert property (p_ctrl_width) else $error("control upper bits set");
endmodule

bind edqo_top edqo_asserts i_chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .divided_phase_a_out_p(divided_phase_a_out_p), .divided_phase_a_out_n(divided_phase_a_out_n),
    .divided_phase_b_out_p(divided_phase_b_out_p), .divided_phase_b_out_n(divided_phase_b_out_n),
    .divided_index_out_p(divided_index_out_p), .divided_index_out_n(divided_index_out_n));

// ### verification/edqo_host_model.sv
// host side receiver: counts quadrature steps and active index cycles
`timescale 1ns/1ps
module edqo_host_model (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          clr,
    input  wire logic          pol,
    input  wire logic          a_p,
    input  wire logic          a_n,
    input  wire logic          b_p,
    input  wire logic          b_n,
    input  wire logic          z_p,
    input  wire logic          z_n,
    output logic signed [15:0] pos_ff,
    output logic        [7:0]  idx_ff
);
    logic a, b, z_act;  // differential receiver levels
    logic a_ff, b_ff;   // previous levels
    assign a = a_p & ~a_n;
    assign b = b_p & ~b_n;
    // active level cycles, so a wrong polarity shows as a long count
    assign z_act = (z_p & ~z_n) ^ pol;
    // decode: a leading b counts up, a double jump counts nothing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {a_ff, b_ff} <= 2'h0;
            pos_ff <= 16'sh0;
            idx_ff <= 8'h00;
        end else begin
            a_ff <= a;
            b_ff <= b;
            if (clr) begin
                pos_ff <= 16'sh0;
                idx_ff <= 8'h00;
            end else begin
                if ((a ^ a_ff) != (b ^ b_ff))
                    pos_ff <= (b_ff ^ a) ? pos_ff + 16'sh1 : pos_ff - 16'sh1;
                if (z_act)
                    idx_ff <= idx_ff + 8'h01;
            end
        end
    end
endmodule

// ### verification/tb_edqo_top.sv
// testbench for the divided quadrature output
`timescale 1ns/1ps
module tb_edqo_top;
    import edqo_pkg::*;
    logic               clk, rst_n, reg_wr, reg_rd, rd_d, snap, clr, pol;
    logic        [3:0]  reg_addr;
    logic        [31:0] reg_wdata, reg_rdata;
    logic        [2:0]  enc, aux;     // a, b, index pins per source
    logic               a_p, a_n, b_p, b_n, z_p, z_n;
    logic signed [15:0] pos;
    logic        [7:0]  idx;
    logic        [31:0] qr[$], qp[$]; // expected reads, expected host counts
    logic        [1:0]  ph[2];        // quadrature phase per source
    int                 errors, n_checks, seed, n;

    edqo_top i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .enc_a_in(enc[2]), .enc_b_in(enc[1]), .enc_z_in(enc[0]),
        .aux_a_in(aux[2]), .aux_b_in(aux[1]), .aux_z_in(aux[0]),
        .divided_phase_a_out_p(a_p), .divided_phase_a_out_n(a_n),
        .divided_phase_b_out_p(b_p), .divided_phase_b_out_n(b_n),
        .divided_index_out_p(z_p), .divided_index_out_n(z_n));
    edqo_host_model i_host (.clk(clk), .rst_n(rst_n), .clr(clr), .pol(pol), .a_p(a_p),
        .a_n(a_n), .b_p(b_p), .b_n(b_n), .z_p(z_p), .z_n(z_n), .pos_ff(pos), .idx_ff(idx));

    // 50 ns period
    always #25 clk = ~clk;

    task automatic end_sim;
        if (errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        qr.push_back(e);
        @(posedge clk);
        reg_rd   <= 1'b0;
    endtask
    // counts 8 cycles apart, well above the filter and output gap
    task automatic mv(input int src, input int cnt, input bit fwd);
        repeat (cnt) begin
            ph[src] = ph[src] + (fwd ? 2'd1 : 2'd3);
            @(posedge clk);
            if (src == 0)
                enc[2:1] <= {^ph[src], ph[src][1]};
            else
                aux[2:1] <= {^ph[src], ph[src][1]};
            repeat (7) @(posedge clk);
        end
    endtask
    task automatic zp(input int src);
        @(posedge clk);
        if (src == 0)
            enc[0] <= 1'b1;
        else
            aux[0] <= 1'b1;
        repeat (8) @(posedge clk);
        enc[0] <= 1'b0;
        aux[0] <= 1'b0;
    endtask
    // let steps drain, note expected counts, then clear host counters
    task automatic pchk(input int p, input int i);
        repeat (40) @(posedge clk);
        qp.push_back({8'h00, 16'(p), 8'(i)});
        snap <= 1'b1;
        clr  <= 1'b1;
        @(posedge clk);
        snap <= 1'b0;
        clr  <= 1'b0;
    endtask

    // result watcher: oldest note against what appears
    always @(posedge clk) rd_d <= reg_rd;
    always @(negedge clk) begin
        if (rd_d === 1'b1)
            cmp(reg_rdata, qr.pop_front());
        if (snap === 1'b1)
            cmp({8'h00, pos, idx}, qp.pop_front());
    end

    // watchdog against a hang
    initial begin
        repeat (30000) @(posedge clk);
        errors++;
        end_sim;
    end

    initial begin
        clk = 1'b0; rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; rd_d = 1'b0;
        snap = 1'b0; clr = 1'b0; pol = 1'b0; reg_addr = 4'h0; reg_wdata = 32'h0;
        enc = 3'h0; aux = 3'h0; ph[0] = 2'h0; ph[1] = 2'h0;
        errors = 0; n_checks = 0; seed = 60;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd(EDQO_CTRL_OFS, 32'h0);
        rd(EDQO_PPR_OFS, 32'h000009C4);
        rd(4'h2, 32'h0);
        wr(EDQO_PPR_OFS, 32'h00000005);
        rd(EDQO_PPR_OFS, 32'h0000000A);
        wr(EDQO_PPR_OFS, 32'h00004E20);
        rd(EDQO_PPR_OFS, 32'h00002710);
        // one edge per count; even counts keep a equal to b for the swap
        for (int d = 0; d < 2; d++) begin
            wr(EDQO_CTRL_OFS, 32'(d));
            n = 2 * (1 + $unsigned($random(seed)) % 5);
            mv(0, n, 1'b1);
            pchk(d ? -n : n, 0);
            mv(0, n, 1'b0);
            pchk(d ? n : -n, 0);
        end
        wr(EDQO_CTRL_OFS, 32'h0);
        wr(EDQO_PPR_OFS, 32'h00001388);
        n = 4 * (1 + $unsigned($random(seed)) % 3);
        mv(0, n, 1'b1);
        pchk(n / 2, 0);
        mv(0, n, 1'b0);
        pchk(-n / 2, 0);
        // auxiliary source feeds the path, motor moves ignored
        wr(EDQO_CTRL_OFS, 32'h4);
        mv(0, 4, 1'b1);
        mv(1, 8, 1'b1);
        pchk(4, 0);
        // eight aux edges forward make four output edges, one full output pulse
        rd(EDQO_COUNT_OFS, 32'h00000001);
        // index polarity: five active cycles per pulse, other source ignored
        for (int p = 0; p < 2; p++) begin
            wr(EDQO_CTRL_OFS, 32'(p << 1));
            // host polarity follows one edge later, as the index pin flop does
            @(posedge clk);
            pol <= 1'(p);
            pchk(0, 0);
            zp(1);
            zp(0);
            pchk(0, 5);
        end
        // both phases jump at once: sticky jump flag, cleared by writing one
        enc[2:1] <= 2'h3;
        repeat (8) @(posedge clk);
        enc[2:1] <= 2'h0;
        repeat (8) @(posedge clk);
        rd(EDQO_STATUS_OFS, 32'(1) << EDQO_ST_ERR_BIT);
        wr(EDQO_STATUS_OFS, 32'(1) << EDQO_ST_ERR_BIT);
        rd(EDQO_STATUS_OFS, 32'h00000000);
        end_sim;
    end
endmodule
